//--- rtl/tcl_defs.svh
// Register offsets, field positions, reset values and timing figures of the conversion and limit block.
`ifndef TCL_DEFS_SVH
`define TCL_DEFS_SVH
// Register addresses seen by the register access port.
`define TCL_ADDR_STATUS 3'h0
`define TCL_ADDR_CONFIG 3'h1
`define TCL_ADDR_TEMP 3'h2
`define TCL_ADDR_ID 3'h3
`define TCL_ADDR_CRIT 3'h4
`define TCL_ADDR_HYST 3'h5
`define TCL_ADDR_HIGH 3'h6
`define TCL_ADDR_LOW 3'h7
// Configuration field positions.
`define TCL_CFG_FQ_LSB 0
`define TCL_CFG_CRIT_POL 2
`define TCL_CFG_INTPOL 3
`define TCL_CFG_IRQMODE 4
`define TCL_CFG_MODE_LSB 5
`define TCL_CFG_RES16 7
// Operating mode encodings.
`define TCL_MODE_CONT 2'h0
`define TCL_MODE_ONESHOT 2'h1
`define TCL_MODE_SPS 2'h2
`define TCL_MODE_SHUT 2'h3
// Power-on values.
`define TCL_CFG_RST 8'h00
`define TCL_TEMP_RST 16'h0000
`define TCL_CRIT_RST 16'h4980
`define TCL_HYST_RST 4'h5
`define TCL_HIGH_RST 16'h2000
`define TCL_LOW_RST 16'h0500
// Timing figures in milliseconds and the clock rate in kHz.
`define TCL_CLK_KHZ 100000
`define TCL_CONV_MS 240
`define TCL_FAST_MS 6
`define TCL_SPS_CONV_MS 60
`define TCL_SPS_IDLE_MS 940
`define TCL_WAKE_MS 1
`endif

//--- rtl/tcl_pkg.sv
// Types shared by the conversion and limit block.
package tcl_pkg;
  // Conversion sequencer states.
  typedef enum logic [2:0] {ST_FAST, ST_CONV, ST_IDLE, ST_WAKE, ST_SHUT} tcl_state_e;
endpackage : tcl_pkg

//--- rtl/tcl_top.sv
// Conversion sequencing, result storage and limit alarm logic of the temperature sensor.
// How it works
// - continuous mode restarts conversion, 240 ms each
// - every finished result goes to temperature register
// - first conversion after power-up is fast, 6 ms
// - default limits trip alarms at 147, 64, 10 C
// - conversions timed by internal clock, not serial
// - compare against critical, upper and lower limits
// - mode 01 runs one conversion then shuts down
// - rewriting 01 starts another single conversion
// - interrupt mode: any register read clears alarms
// - one-shot comparator: mode write clears limit alarm
// - one-shot comparator: mode write clears critical alarm
// - mode 10: 60 ms conversion, 940 ms idle
// - 11 shuts down, 00 wakes after 1 ms
// - shutdown keeps last result readable
// - leaving shutdown starts a new conversion
// - alarms need the configured consecutive fault count
// - non-fault conversion clears fault counter
// - LSB is 0.0625 C or 0.0078 C
// - 13-bit format carries low/high/crit flags in bits 2:0
// - configuration bit 7 selects 16-bit results
// - fault field 00..11 means 1..4 faults
// - critical alarm polarity set by its polarity bit
`include "tcl_defs.svh"
module tcl_top import tcl_pkg::*; #(
  parameter int CONV_CYC = `TCL_CONV_MS * `TCL_CLK_KHZ,
  parameter int FAST_CYC = `TCL_FAST_MS * `TCL_CLK_KHZ,
  parameter int SPS_CONV_CYC = `TCL_SPS_CONV_MS * `TCL_CLK_KHZ,
  parameter int SPS_IDLE_CYC = `TCL_SPS_IDLE_MS * `TCL_CLK_KHZ,
  parameter int WAKE_CYC = `TCL_WAKE_MS * `TCL_CLK_KHZ
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [15:0] adc_sample,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata_r,
  output logic critical_alarm_out_r,
  output logic limit_alarm_out_r
);
  // Reset synchroniser stages; rst_n_r is the released copy used everywhere.
  logic rst_m_r;
  logic rst_n_r;
  // Two-stage capture of the modulator word, which comes from outside this clock.
  logic [15:0] samp_m_r;
  logic [15:0] samp_r;
  // Programmable registers and the measured temperature result.
  logic [7:0] sensor_configuration_r;
  logic [15:0] measured_temperature_r;
  logic [15:0] critical_limit_r;
  logic [3:0] limit_hysteresis_r;
  logic [15:0] upper_limit_r;
  logic [15:0] lower_limit_r;
  // Sequencer state and its down counter.
  tcl_state_e state_r;
  logic [26:0] cnt_r;
  // Fault queue counter and the two alarm states.
  logic [2:0] fault_cnt_r;
  logic crit_act_r;
  logic lim_act_r;
  // Decoded helpers.
  logic [1:0] mode;
  logic mode_wr;
  logic conv_done;
  logic [15:0] res;
  logic [15:0] hyst;
  logic over_crit;
  logic over_high;
  logic under_low;
  logic any_fault;
  logic queue_full;
  logic crit_in_band;
  logic lim_in_band;

  // Truncates a word to the active resolution so comparisons use only live bits.
  function automatic logic [15:0] at_res(input logic [15:0] v, input logic r16);
    at_res = r16 ? v : {v[15:3], 3'h0};
  endfunction : at_res

  // Signed greater-than of two words at the active resolution.
  function automatic logic sgt(input logic [15:0] a, input logic [15:0] b, input logic r16);
    sgt = $signed(at_res(a, r16)) > $signed(at_res(b, r16));
  endfunction : sgt

  // Reset release through two flip-flops.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_m_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_n_r <= rst_m_r;
    end
  end

  // Modulator word synchroniser; only the second stage is read.
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      samp_m_r <= 16'h0000;
      samp_r <= 16'h0000;
    end else begin
      samp_m_r <= adc_sample;
      samp_r <= samp_m_r;
    end
  end

  assign mode = sensor_configuration_r[`TCL_CFG_MODE_LSB +: 2];
  assign mode_wr = reg_wr && (reg_addr == `TCL_ADDR_CONFIG);
  assign conv_done = (state_r == ST_FAST || state_r == ST_CONV) && (cnt_r == 27'h0000000);
  assign res = at_res(samp_r, sensor_configuration_r[`TCL_CFG_RES16]);
  // Hysteresis is whole degrees; one degree is 128 counts of the 16-bit word.
  assign hyst = {5'h00, limit_hysteresis_r, 7'h00};
  // Signed limit comparisons at the selected resolution.
  assign over_crit = sgt(res, critical_limit_r, sensor_configuration_r[`TCL_CFG_RES16]);
  assign over_high = sgt(res, upper_limit_r, sensor_configuration_r[`TCL_CFG_RES16]);
  assign under_low = sgt(lower_limit_r, res, sensor_configuration_r[`TCL_CFG_RES16]);
  assign any_fault = over_crit || over_high || under_low;
  // The field value plus one is the number of consecutive faults required.
  assign queue_full = ({1'b0, fault_cnt_r} + 4'h1) >= ({2'h0, sensor_configuration_r[1:0]} + 4'h1);
  assign crit_in_band = !sgt(res, critical_limit_r - hyst, 1'b1);
  assign lim_in_band = !sgt(res, upper_limit_r - hyst, 1'b1) && !sgt(lower_limit_r + hyst, res, 1'b1);

  // Register writes from the access port; setpoints and configuration are writable.
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sensor_configuration_r <= `TCL_CFG_RST;
      critical_limit_r <= `TCL_CRIT_RST;
      limit_hysteresis_r <= `TCL_HYST_RST;
      upper_limit_r <= `TCL_HIGH_RST;
      lower_limit_r <= `TCL_LOW_RST;
    end else if (reg_wr) begin
      if (reg_addr == `TCL_ADDR_CONFIG) begin
        sensor_configuration_r <= reg_wdata[7:0];
      end else if (reg_addr == `TCL_ADDR_CRIT) begin
        critical_limit_r <= reg_wdata;
      end else if (reg_addr == `TCL_ADDR_HYST) begin
        limit_hysteresis_r <= reg_wdata[3:0];
      end else if (reg_addr == `TCL_ADDR_HIGH) begin
        upper_limit_r <= reg_wdata;
      end else if (reg_addr == `TCL_ADDR_LOW) begin
        lower_limit_r <= reg_wdata;
      end
    end
  end

  // Conversion sequencer, counted on mclk only, never on the serial clock.
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= ST_FAST;
      cnt_r <= 27'(FAST_CYC - 1);
    end else if (mode_wr) begin
      // A mode write takes effect at once.
      case (reg_wdata[`TCL_CFG_MODE_LSB +: 2])
        `TCL_MODE_ONESHOT: begin
          state_r <= ST_CONV;
          cnt_r <= 27'(CONV_CYC - 1);
        end
        `TCL_MODE_SPS: begin
          state_r <= ST_CONV;
          cnt_r <= 27'(SPS_CONV_CYC - 1);
        end
        `TCL_MODE_SHUT: begin
          state_r <= ST_SHUT;
          cnt_r <= 27'h0000000;
        end
        default: begin
          // Continuous: wake from shutdown, start a conversion from idle, otherwise keep running.
          if (state_r == ST_SHUT) begin
            state_r <= ST_WAKE;
            cnt_r <= 27'(WAKE_CYC - 1);
          end else if (state_r == ST_IDLE) begin
            state_r <= ST_CONV;
            cnt_r <= 27'(CONV_CYC - 1);
          end
        end
      endcase
    end else begin
      case (state_r)
        ST_FAST, ST_CONV: begin
          if (cnt_r != 27'h0000000) begin
            cnt_r <= cnt_r - 27'h0000001;
          end else if (mode == `TCL_MODE_CONT) begin
            state_r <= ST_CONV;
            cnt_r <= 27'(CONV_CYC - 1);
          end else if (mode == `TCL_MODE_SPS) begin
            state_r <= ST_IDLE;
            cnt_r <= 27'(SPS_IDLE_CYC - 1);
          end else begin
            state_r <= ST_SHUT;
          end
        end
        ST_IDLE: begin
          if (cnt_r != 27'h0000000) begin
            cnt_r <= cnt_r - 27'h0000001;
          end else begin
            state_r <= ST_CONV;
            cnt_r <= 27'(SPS_CONV_CYC - 1);
          end
        end
        ST_WAKE: begin
          if (cnt_r != 27'h0000000) begin
            cnt_r <= cnt_r - 27'h0000001;
          end else begin
            state_r <= ST_CONV;
            cnt_r <= 27'(CONV_CYC - 1);
          end
        end
        default: begin
          // Shutdown holds until a mode write.
          cnt_r <= 27'h0000000;
        end
      endcase
    end
  end

  // Result storage; 13-bit mode places the three limit flags in the low bits.
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      measured_temperature_r <= `TCL_TEMP_RST;
    end else if (conv_done) begin
      if (sensor_configuration_r[`TCL_CFG_RES16]) begin
        measured_temperature_r <= samp_r;
      end else begin
        measured_temperature_r <= {samp_r[15:3], under_low, over_high, over_crit};
      end
    end
  end

  // Consecutive fault counter.
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      fault_cnt_r <= 3'h0;
    end else if (conv_done) begin
      if (!any_fault) begin
        fault_cnt_r <= 3'h0;
      end else if (!queue_full) begin
        fault_cnt_r <= fault_cnt_r + 3'h1;
      end
    end
  end

  // Alarm states; a setting conversion wins over any clear in the same cycle.
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      crit_act_r <= 1'b0;
      lim_act_r <= 1'b0;
    end else begin
      if (conv_done && queue_full && over_crit) begin
        crit_act_r <= 1'b1;
      end else if (sensor_configuration_r[`TCL_CFG_IRQMODE] && reg_rd) begin
        crit_act_r <= 1'b0;
      end else if (!sensor_configuration_r[`TCL_CFG_IRQMODE] && crit_in_band && (conv_done || mode_wr)) begin
        crit_act_r <= 1'b0;
      end
      if (conv_done && queue_full && (over_high || under_low)) begin
        lim_act_r <= 1'b1;
      end else if (sensor_configuration_r[`TCL_CFG_IRQMODE] && reg_rd) begin
        lim_act_r <= 1'b0;
      end else if (!sensor_configuration_r[`TCL_CFG_IRQMODE] && lim_in_band && (conv_done || mode_wr)) begin
        lim_act_r <= 1'b0;
      end
    end
  end

  // Pin levels: polarity bit 0 drives the active state low.
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      critical_alarm_out_r <= 1'b1;
      limit_alarm_out_r <= 1'b1;
    end else begin
      critical_alarm_out_r <= ~(crit_act_r ^ sensor_configuration_r[`TCL_CFG_CRIT_POL]);
      limit_alarm_out_r <= ~(lim_act_r ^ sensor_configuration_r[`TCL_CFG_INTPOL]);
    end
  end

  // Read data, one cycle after the read strobe; the result stays readable in shutdown.
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      reg_rdata_r <= 16'h0000;
    end else if (reg_rd) begin
      if (reg_addr == `TCL_ADDR_CONFIG) begin
        reg_rdata_r <= {8'h00, sensor_configuration_r};
      end else if (reg_addr == `TCL_ADDR_TEMP) begin
        reg_rdata_r <= measured_temperature_r;
      end else if (reg_addr == `TCL_ADDR_CRIT) begin
        reg_rdata_r <= critical_limit_r;
      end else if (reg_addr == `TCL_ADDR_HYST) begin
        reg_rdata_r <= {12'h000, limit_hysteresis_r};
      end else if (reg_addr == `TCL_ADDR_HIGH) begin
        reg_rdata_r <= upper_limit_r;
      end else if (reg_addr == `TCL_ADDR_LOW) begin
        reg_rdata_r <= lower_limit_r;
      end else begin
        reg_rdata_r <= 16'h0000;
      end
    end
  end

  // Checks on sequencing, storage and alarms.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n_r);
  a_fast_then_conv: assert property (state_r == ST_FAST && conv_done && !mode_wr |=> state_r == ST_CONV)
    else $error("Fast conversion did not hand over to a normal one.");
  a_cont_restart: assert property (conv_done && !mode_wr && mode == `TCL_MODE_CONT
    |=> state_r == ST_CONV && cnt_r == 27'(CONV_CYC - 1))
    else $error("Continuous mode did not restart a full conversion.");
  a_result_store: assert property (conv_done |=> measured_temperature_r[15:3] == $past(samp_r[15:3]))
    else $error("Finished result was not stored.");
  a_oneshot_start: assert property (mode_wr && reg_wdata[6:5] == `TCL_MODE_ONESHOT
    |=> state_r == ST_CONV ##1 state_r == ST_CONV)
    else $error("One-shot write did not start a conversion.");
  a_shut_enter: assert property (mode_wr && reg_wdata[6:5] == `TCL_MODE_SHUT |=> state_r == ST_SHUT)
    else $error("Shutdown write did not stop conversions.");
  a_shut_hold: assert property (state_r == ST_SHUT |=> $stable(measured_temperature_r))
    else $error("Result changed while shut down.");
  a_irq_read_clear: assert property (sensor_configuration_r[4] && reg_rd && !conv_done && !reg_wr
    |=> !crit_act_r && !lim_act_r ##1 critical_alarm_out_r == ~sensor_configuration_r[2])
    else $error("Read did not clear alarms in interrupt mode.");
  a_fault_clear: assert property (conv_done && !any_fault |=> fault_cnt_r == 3'h0)
    else $error("Fault counter not cleared by a clean result.");
  a_crit_polarity: assert property (critical_alarm_out_r == ~($past(crit_act_r) ^ $past(sensor_configuration_r[2])))
    else $error("Critical alarm pin has the wrong polarity.");
  c_cont_conv: cover property (conv_done && mode == `TCL_MODE_CONT ##1 state_r == ST_CONV);
  c_crit_alarm: cover property (!crit_act_r ##1 crit_act_r);
  c_wake: cover property (state_r == ST_WAKE ##1 state_r == ST_CONV);
  c_sps_idle: cover property (state_r == ST_IDLE);
endmodule : tcl_top

//--- verification/tcl_host_model.sv
// Register host model that issues the strobe protocol of the conversion and limit block.
module tcl_host_model (
  input wire logic mclk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [2:0] reg_addr,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata_r
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle values at time zero; no strobe is raised before the bench asks.
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 16'hA5A5;
  end

  // One write strobe for one cycle; the data lines are inverted afterwards so stale data is never reused.
  task automatic wr(input logic [2:0] addr, input logic [15:0] data);
    @(negedge mclk);
    reg_wr = 1'b1;
    reg_addr = addr;
    reg_wdata = data;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_wdata = ~data;
  endtask : wr

  // One read strobe; the whole 16-bit word is taken as the two bytes of one transfer.
  task automatic rd(input logic [2:0] addr, output logic [15:0] data);
    @(negedge mclk);
    reg_rd = 1'b1;
    reg_addr = addr;
    @(negedge mclk);
    reg_rd = 1'b0;
    data = reg_rdata_r;
  endtask : rd
endmodule : tcl_host_model

//--- verification/testbench.sv
// Self-checking bench for the conversion sequencing and limit alarm block.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CONV = 20;
  localparam int FAST = 5;
  localparam int SCONV = 10;
  localparam int SIDLE = 30;
  localparam int WAKE = 4;

  logic mclk = 1'b0; // System clock, 100 MHz.
  logic arst_n = 1'b0; // Asynchronous reset, active low.
  logic [15:0] adc_sample = 16'h0C87; // Modulator word fed to the design.
  logic reg_wr, reg_rd; // Strobes from the host model.
  logic [2:0] reg_addr; // Register address from the host model.
  logic [15:0] reg_wdata, reg_rdata_r; // Write and read data.
  logic crit_pin, int_pin; // Alarm pin levels.
  logic [15:0] rv; // Last value read.
  int err_total = 0; // Mismatches seen.
  int checks_done = 0; // Comparisons made.
  int cyc = 0; // Cycle counter for the hang guard.
  logic [15:0] exp_reset [8] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h4980, 16'h0005, 16'h2000, 16'h0500};
  logic [15:0] lim_tab [4][4] = '{'{16'h2080, 16'h2082, 16'h1, 16'h0}, '{16'h4A00, 16'h4A03, 16'h0, 16'h0},
                                  '{16'hFE00, 16'hFE04, 16'h1, 16'h0}, '{16'h0C87, 16'h0C80, 16'h1, 16'h1}};

  // Clock generation.
  always #5 mclk = ~mclk;

  tcl_top #(.CONV_CYC(CONV), .FAST_CYC(FAST), .SPS_CONV_CYC(SCONV), .SPS_IDLE_CYC(SIDLE), .WAKE_CYC(WAKE)) dut_u (
    .mclk(mclk), .arst_n(arst_n), .adc_sample(adc_sample), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .critical_alarm_out_r(crit_pin), .limit_alarm_out_r(int_pin));

  tcl_host_model host_u (
    .mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_r(reg_rdata_r));

  // Prints the verdict and ends the run.
  task automatic close_out;
    if (err_total == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  // Compares one value against its expectation.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Waits a number of cycles, landing on a falling edge.
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : wait_cyc

  // Reads a register and compares it.
  task automatic rd_chk(input logic [2:0] addr, input logic [15:0] exp);
    host_u.rd(addr, rv);
    chk(rv, exp);
  endtask : rd_chk

  // Compares both alarm pins.
  task automatic pins(input logic crit, input logic lim);
    chk({15'h0, crit_pin}, {15'h0, crit});
    chk({15'h0, int_pin}, {15'h0, lim});
  endtask : pins

  // Hang guard.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end

  // Main test sequence.
  initial begin
    wait_cyc(4);
    arst_n = 1'b1;
    pins(1'b1, 1'b1);
    wait_cyc(3);
    for (int a = 0; a < 8; a++) begin
      if (a != 2) begin
        rd_chk(a[2:0], exp_reset[a]);
      end
    end
    rd_chk(3'h2, 16'h0C80);
    wait_cyc(2 * CONV);
    rd_chk(3'h2, 16'h0C80);
    host_u.wr(3'h1, 16'h0080);
    wait_cyc(2 * CONV + 10);
    rd_chk(3'h2, 16'h0C87);
    host_u.wr(3'h1, 16'h0000);
    // Each limit case in turn, including a negative sample below the lower limit.
    for (int i = 0; i < 4; i++) begin
      adc_sample = lim_tab[i][0];
      wait_cyc(2 * CONV + 10);
      rd_chk(3'h2, lim_tab[i][1]);
      pins(lim_tab[i][2][0], lim_tab[i][3][0]);
    end
    adc_sample = 16'h4A00;
    host_u.wr(3'h1, 16'h0004);
    wait_cyc(2 * CONV + 10);
    pins(1'b1, 1'b0);
    host_u.wr(3'h1, 16'h0000);
    // Fault queue depth for every code of the field.
    for (int fq = 0; fq < 4; fq++) begin
      adc_sample = 16'h0C87;
      wait_cyc(2 * CONV + 10);
      host_u.wr(3'h1, {14'h0, fq[1:0]});
      adc_sample = 16'h2080;
      if (fq > 0) begin
        wait_cyc(fq * CONV - 5);
        pins(1'b1, 1'b1);
      end
      wait_cyc(50);
      pins(1'b1, 1'b0);
    end
    adc_sample = 16'h0C87;
    wait_cyc(2 * CONV + 10);
    adc_sample = 16'h2080;
    wait_cyc(CONV + 10);
    adc_sample = 16'h0C87;
    wait_cyc(CONV + 10);
    adc_sample = 16'h2080;
    wait_cyc(3 * CONV - 5);
    pins(1'b1, 1'b1);
    host_u.wr(3'h1, 16'h0000);
    adc_sample = 16'h1007;
    wait_cyc(2 * CONV + 10);
    // One-shot runs once, stays in shutdown, and reruns on a fresh mode write.
    host_u.wr(3'h1, 16'h0020);
    wait_cyc(CONV + 10);
    rd_chk(3'h2, 16'h1000);
    adc_sample = 16'h1107;
    wait_cyc(2 * CONV + 10);
    rd_chk(3'h2, 16'h1000);
    host_u.wr(3'h1, 16'h0020);
    wait_cyc(CONV + 10);
    rd_chk(3'h2, 16'h1100);
    host_u.wr(3'h2, 16'h1234);
    rd_chk(3'h2, 16'h1100);
    // One-shot comparator mode: a later mode write clears both alarms once the input is back in band.
    adc_sample = 16'h4A00;
    host_u.wr(3'h1, 16'h0020);
    wait_cyc(CONV + 10);
    pins(1'b0, 1'b0);
    adc_sample = 16'h0C87;
    wait_cyc(10);
    pins(1'b0, 1'b0);
    host_u.wr(3'h1, 16'h0060);
    wait_cyc(2);
    pins(1'b1, 1'b1);
    // Interrupt mode: a read of any register clears both pins.
    adc_sample = 16'h4A00;
    host_u.wr(3'h1, 16'h0030);
    wait_cyc(CONV + 10);
    pins(1'b0, 1'b0);
    host_u.rd(3'h0, rv);
    wait_cyc(2);
    pins(1'b1, 1'b1);
    // Shutdown keeps the last result; leaving it starts a new conversion.
    host_u.wr(3'h1, 16'h0060);
    adc_sample = 16'h0C87;
    wait_cyc(2 * CONV + 10);
    rd_chk(3'h2, 16'h4A03);
    host_u.wr(3'h1, 16'h0000);
    wait_cyc(WAKE + CONV + 10);
    rd_chk(3'h2, 16'h0C80);
    host_u.wr(3'h1, 16'h0040);
    adc_sample = 16'h1007;
    wait_cyc(2 * (SCONV + SIDLE) + 10);
    rd_chk(3'h2, 16'h1000);
    rd_chk(3'h1, 16'h0040);
    // Programmed limits replace the defaults; a lower limit above the input trips the limit alarm.
    host_u.wr(3'h4, 16'h3000);
    rd_chk(3'h4, 16'h3000);
    host_u.wr(3'h5, 16'h000A);
    rd_chk(3'h5, 16'h000A);
    host_u.wr(3'h6, 16'h2800);
    rd_chk(3'h6, 16'h2800);
    host_u.wr(3'h7, 16'h1800);
    rd_chk(3'h7, 16'h1800);
    wait_cyc(2 * (SCONV + SIDLE) + 10);
    rd_chk(3'h2, 16'h1004);
    pins(1'b1, 1'b0);
    close_out();
  end
endmodule : testbench
